// >>> dv/fcp_full_compare_pwm_tb.sv
// Testbench: register-driven scenarios for the full compare PWM block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin numErrors++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end
module fcp_full_compare_pwm_tb;
    import fcp_pkg::*;
    localparam logic [15:0] CC_TAB [0:2] = '{16'h8302, 16'h8300, 16'h8002}; // Cause table
    localparam logic PROT_TAB [0:2] = '{1'b0, 1'b0, 1'b1};
    localparam logic [6:0] OE_TAB [0:2] = '{7'h7F, 7'h00, 7'h7F};
    logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, protN = 1;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2; // Word transfers only
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp;
    logic [2:0] upperOn;
    fcp_pins_t pins;
    int faultCount, numErrors = 0, comparisons = 0, w, p, n, x;
    time t0; // Start of a measured pulse
    // Single slave, so its ready is the bus ready
    fcp_full_compare_pwm DUT (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .powerDriveProtectN(protN),
        .pins(pins));
    fcp_inverter_model INV (.clk(clk), .pins(pins), .upperOn(upperOn), .faultCount(faultCount));
    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task wrapUp;
        $display("Errors %0d, comparisons %0d", numErrors, comparisons);
        if (numErrors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Bounded wait for ready at a rising edge
    task waitRdy;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            numErrors++;
            wrapUp;
        end
    endtask
    // One word: address phase, then data phase; read data taken at its end
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        waitRdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy;
        rd = hrdata;
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    // Edges until pin 0 shows v; a lapse ends the run
    task waitFor(input logic v, output int c);
        c = 0;
        while (pins.level[0] !== v && c < 300) begin
            @(posedge clk);
            c++;
        end
        if (c >= 300) begin
            numErrors++;
            wrapUp;
        end
    endtask
    // High width of pin 0, then fall-to-fall period
    task pulse(output int wd, output int pd);
        int a;
        waitFor(1'b0, a);
        waitFor(1'b1, a);
        waitFor(1'b0, wd);
        waitFor(1'b1, a);
        waitFor(1'b0, pd);
        pd += a;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        tick(10);
        resetn <= 1'b1;
        tick(1);
        xfer(0, OFF_TIMER1_PERIOD, 0);
        `CHK(rd, 32'h0000FFFF, "period reset")
        xfer(0, 8'h2C, 0);
        `CHK(rd, 32'h0, "unmapped read")
        `CHK(pins.oeN, 7'h7F, "reset hiz")
        // Setup in the documented order; 5 dead-band clocks, all pairs
        // All six pair pins active high, so a pair never shows both pins high
        xfer(1, OFF_ACTION, 32'hAAA);
        xfer(1, OFF_DEADBAND, 32'hABCD05E0);
        xfer(0, OFF_DEADBAND, 0);
        `CHK(rd, 32'h05E0, "dead band fields")
        xfer(1, OFF_CMP1, 32'h8);
        xfer(1, OFF_CMP2, 32'hC);
        xfer(1, OFF_CMP3, 32'h11);
        xfer(1, OFF_TIMER1_PERIOD, 32'h14);
        xfer(1, OFF_CCTRL, 32'h0302);
        xfer(1, OFF_CCTRL, 32'h8302);
        tick(3);
        `CHK(pins.oeN, 7'h00, "outputs on")
        `CHK(pins.level[0], 1'b0, "inactive start")
        xfer(1, OFF_T1CTRL, 32'h1);
        pulse(w, p);
        pulse(w, p);
        `CHK(w, 8, "edge width")
        `CHK(p, 21, "edge period")
        // Writes just after a fall leave the running period alone
        waitFor(1'b1, x);
        waitFor(1'b0, x);
        xfer(1, OFF_CMP1, 32'hC);
        xfer(1, OFF_TIMER1_PERIOD, 32'h1C);
        pulse(w, p);
        `CHK(w, 8, "shadowed compare")
        `CHK(p, 29, "shadowed period")
        pulse(w, p);
        `CHK(w, 12, "new compare")
        xfer(1, OFF_T1CTRL, 32'h2);
        pulse(w, p);
        pulse(w, p);
        `CHK(w, 28, "centred width")
        `CHK(p, 56, "centred period")
        // New compare written while high in the up half moves the falling edge only
        waitFor(1'b1, x);
        t0 = $time;
        xfer(1, OFF_CMP1, 32'h10);
        waitFor(1'b0, x);
        `CHK(int'(($time - t0) / 25), 24, "reload at period match")
        // Every upper-leg pattern
        for (int c = 0; c < 8; c++) begin
            xfer(1, OFF_CMP1, c[2] ? 0 : 32'hFFFF);
            xfer(1, OFF_CMP2, c[1] ? 0 : 32'hFFFF);
            xfer(1, OFF_CMP3, c[0] ? 0 : 32'hFFFF);
            tick(80);
            xfer(0, OFF_STATUS, 0);
            `CHK(rd[18:16], c[2:0], "pattern")
            `CHK(rd[19], (c == 0 || c == 7), "zero vector")
            `CHK(upperOn, c[2:0], "gate pattern")
        end
        // Pin 0 polarity with pin 1 held low, for both raw levels
        for (int r = 0; r < 2; r++) begin
            for (int m = 0; m < 4; m++) begin
                xfer(1, OFF_CMP1, r ? 0 : 32'hFFFF);
                xfer(1, OFF_ACTION, 32'hAA0 | m);
                tick(80);
                `CHK(pins.level[0], (m == 3) || (m == 2 && r == 1) || (m == 1 && r == 0),
                    "polarity")
            end
        end
        // Protection unmasked, masked, and enables cleared
        for (int k = 0; k < 3; k++) begin
            xfer(1, OFF_CCTRL, CC_TAB[k]);
            protN <= PROT_TAB[k];
            tick(4);
            `CHK(pins.oeN, OE_TAB[k], "hiz cause")
        end
        protN <= 1'b1;
        // Simple compare on either timer
        xfer(1, OFF_T2PER, 32'h1C);
        for (int s = 0; s < 2; s++) begin
            for (int v = 0; v < 2; v++) begin
                xfer(1, OFF_CCTRL, 32'h8322 | s);
                xfer(1, OFF_SCMP, v ? 32'hFFFF : 0);
                tick(80);
                `CHK(pins.level[6], v == 0, "simple compare")
            end
        end
        resetn <= 1'b0;
        tick(2);
        `CHK(pins.oeN, 7'h7F, "mid-run reset")
        resetn <= 1'b1;
        tick(2);
        `CHK(faultCount, 0, "shoot-through")
        wrapUp;
    end
endmodule
bind fcp_full_compare_pwm fcp_pwm_monitor MON (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .powerDriveProtectN(powerDriveProtectN), .pins(pins));
`default_nettype wire

// >>> dv/fcp_inverter_model.sv
// Partner: gate-driver model of the three inverter legs
`timescale 1ns/1ps
`default_nettype none
module fcp_inverter_model (
    input wire logic clk,
    input wire fcp_pkg::fcp_pins_t pins,
    output logic [2:0] upperOn,
    output int faultCount
);
    import fcp_pkg::*;
    // ----------------------------------------
    // Gate inputs
    // ----------------------------------------
    // Driver inputs have pull-downs, so a released pin reads off
    wire logic [5:0] gate = pins.level[5:0] & ~pins.oeN[5:0];
    // Upper legs as the {a,b,c} switching pattern
    assign upperOn = {gate[0], gate[2], gate[4]};
    // Both switches of one leg on is a shoot-through
    initial begin
        faultCount = 0;
        forever begin
            @(posedge clk);
            if ((gate[0] && gate[1]) || (gate[2] && gate[3]) || (gate[4] && gate[5])) begin
                faultCount++;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/fcp_pwm_monitor.sv
// Checker: bus and pin relations of the full compare PWM block
`timescale 1ns/1ps
`default_nettype none
module fcp_pwm_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic powerDriveProtectN,
    input wire fcp_pkg::fcp_pins_t pins
);
    import fcp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic rdPh, wrPh, wrCc; // Data phase markers
    logic [15:0] cc; // Copy of compare control
    wire logic take = hsel && htrans[1] && hready;
    // Output-off cause seen from the bus; level, not latched
    wire logic offCause = !(cc[CC_OE_HI] && cc[CC_OE_LO])
        || (cc[CC_PROT_UNMASK] && !powerDriveProtectN);
    // Track phases and the compare control contents
    always_ff @(posedge clk) begin
        if (!resetn) begin
            {rdPh, wrPh, wrCc, cc} <= '0;
        end else begin
            rdPh <= take && !hwrite;
            wrPh <= take && hwrite;
            wrCc <= take && hwrite && (haddr == OFF_CCTRL);
            cc <= (wrCc && hready) ? hwdata[15:0] : cc;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_reset_hiz; $rose(resetn) |-> pins.oeN == 7'h7F && pins.level == 7'h00; endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("pins not idle after reset");
    property p_oe_uniform; pins.oeN == 7'h00 || pins.oeN == 7'h7F; endproperty
    a_oe_uniform: assert property (p_oe_uniform) else $error("enables split");
    property p_hiz; offCause [*3] |-> pins.oeN == 7'h7F; endproperty
    a_hiz: assert property (p_hiz) else $error("pins driven while disabled");
    property p_drive; !offCause [*3] |-> pins.oeN == 7'h00; endproperty
    a_drive: assert property (p_drive) else $error("pins released while enabled");
    property p_no_shoot; !(pins.level[0] && pins.level[1]) && !(pins.level[2] && pins.level[3])
        && !(pins.level[4] && pins.level[5]); endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("both gates of a leg high");
    property p_db_rise; $rose(pins.level[0]) |-> !$past(pins.level[1]) && !$past(pins.level[1], 2);
    endproperty
    a_db_rise: assert property (p_db_rise) else $error("no gap before upper turn-on");
    property p_rd_wait; rdPh |-> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_zero; wrPh |-> hreadyout; endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("write stalled");
    property p_rd_hold; !rdPh |=> $stable(hrdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
endmodule
`default_nettype wire

// >>> logic/fcp_full_compare_pwm.sv
// Module: three-channel full compare PWM generator with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: Edge- and centre-aligned PWM; three-phase output
// R2: Simple compare selects timer 1 or 2
// R3: Software follows the documented setup order
// R4: Software writes compare control twice first
// R5: Edge-aligned needs continuous up counting
// R6: Period register holds carrier period count
// R7: Software enables compare, PWM and outputs
// R8: Upper byte of dead-band holds count
// R9: Partner output held low or high
// R10: Compare values are double-buffered
// R11: Action and period registers buffered too
// R12: Centre-aligned needs continuous up/down counting
// R13: Centre-aligned gives two matches per period
// R14: Compare reloads at period match too
// R15: Lower gate low whenever upper is high
// R16: Upper gates form 3-bit switching pattern
// R17: Adjacent vectors differ in one bit
// R18: All-zero and all-one are zero vectors
// R19: High-impedance on disable, protection or reset
// R20: Dead-band register fields: count, enables, prescale
// R21: Rising edges delayed by dead-band count
// R22: Two-bit action selects pin polarity
module fcp_full_compare_pwm #(
    parameter int TW = 16  // Timer and compare width
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic powerDriveProtectN,  // Protection input, active low
    output fcp_pkg::fcp_pins_t pins
);
    import fcp_pkg::*;

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (TW < 8 || TW > 16) begin : g_bad_width
        $error("TW must lie between 8 and 16");
    end

    // Pin polarity from a two-bit action field
    function automatic logic polarity(input logic [1:0] act, input logic wave);
        case (act)
            2'h0: polarity = 1'b0;  // Forced low
            2'h1: polarity = ~wave;  // Active low
            2'h2: polarity = wave;  // Active high
            default: polarity = 1'b1;  // Forced high
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic wrPend_reg;  // Write data phase pending
    logic rdPend_reg;  // Read data phase, wait cycle
    logic rdDone_reg;  // Read data ready
    logic [7:0] addr_reg;  // Latched address phase
    logic [31:0] hrdata_reg;
    wire logic addrPhase = hsel & htrans[1] & hready;
    wire logic doWrite = wrPend_reg;
    wire logic wrAction = doWrite && addr_reg == OFF_ACTION;
    wire logic wrDead = doWrite && addr_reg == OFF_DEADBAND;
    wire logic wrCmp1 = doWrite && addr_reg == OFF_CMP1;
    wire logic wrCmp2 = doWrite && addr_reg == OFF_CMP2;
    wire logic wrCmp3 = doWrite && addr_reg == OFF_CMP3;
    wire logic wrCctrl = doWrite && addr_reg == OFF_CCTRL;
    wire logic wrT1ctrl = doWrite && addr_reg == OFF_T1CTRL;
    wire logic wrT1per = doWrite && addr_reg == OFF_TIMER1_PERIOD;
    wire logic wrT2per = doWrite && addr_reg == OFF_T2PER;
    wire logic wrScmp = doWrite && addr_reg == OFF_SCMP;

    // Wait state on reads so a write just before is always seen
    assign hreadyout = ~rdPend_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wrPend_reg <= addrPhase & hwrite;
            rdPend_reg <= addrPhase & ~hwrite;
            if (addrPhase) begin
                addr_reg <= haddr;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers: software copies and active shadows
    // ----------------------------------------------------------------
    logic [15:0] action_reg, actionAct_reg;  // Output action control
    logic [15:0] deadBand_reg;  // Dead-band control
    logic [15:0] cmpCtrl_reg;  // Compare control
    logic [1:0] t1Ctrl_reg;  // Timer 1 mode
    logic [TW-1:0] cmp_reg [3];  // Full compare values, written copy
    logic [TW-1:0] cmpAct_reg [3];  // Values in force
    logic [TW-1:0] per_reg, perAct_reg;  // Timer 1 period
    logic [TW-1:0] t2Per_reg, sCmp_reg;  // Timer 2 period, simple compare
    logic [TW-1:0] cnt_reg, t2Cnt_reg;  // Timer counters
    logic down_reg;  // Timer 1 direction
    fcp_mode_t mode;
    assign mode = fcp_mode_t'(t1Ctrl_reg);

    wire logic zeroHit = cnt_reg == '0;
    wire logic perHit = cnt_reg == perAct_reg;
    // Centre-aligned mode also reloads at the period match
    wire logic cmpLoad = zeroHit | (mode == FCP_UPDOWN & perHit);  // see R14

    always_ff @(posedge clk) begin
        if (!resetn) begin
            action_reg <= RST_ZERO;
            deadBand_reg <= RST_ZERO;
            cmpCtrl_reg <= RST_ZERO;
            t1Ctrl_reg <= 2'h0;
            per_reg <= TW'(RST_PERIOD);
            t2Per_reg <= TW'(RST_PERIOD);
            sCmp_reg <= TW'(RST_ZERO);
            for (int i = 0; i < 3; i++) begin
                cmp_reg[i] <= TW'(RST_ZERO);
            end
        end else begin
            if (wrAction) action_reg <= hwdata[15:0];
            if (wrDead) deadBand_reg <= hwdata[15:0];  // see R20
            if (wrCctrl) cmpCtrl_reg <= hwdata[15:0];
            if (wrT1ctrl) t1Ctrl_reg <= hwdata[1:0];
            if (wrT1per) per_reg <= hwdata[TW-1:0];
            if (wrT2per) t2Per_reg <= hwdata[TW-1:0];
            if (wrScmp) sCmp_reg <= hwdata[TW-1:0];
            if (wrCmp1) cmp_reg[0] <= hwdata[TW-1:0];
            if (wrCmp2) cmp_reg[1] <= hwdata[TW-1:0];
            if (wrCmp3) cmp_reg[2] <= hwdata[TW-1:0];
        end
    end

    // Action and period shadows load only at counter zero; compare shadows
    // also load at the period match in centre-aligned mode
    always_ff @(posedge clk) begin
        if (!resetn) begin
            actionAct_reg <= RST_ZERO;
            perAct_reg <= TW'(RST_PERIOD);
            for (int i = 0; i < 3; i++) begin
                cmpAct_reg[i] <= TW'(RST_ZERO);
            end
        end else begin
            if (zeroHit) begin
                actionAct_reg <= action_reg;  // see R11
                perAct_reg <= per_reg;  // see R11
            end
            if (cmpLoad) begin
                cmpAct_reg <= cmp_reg;  // see R10
            end
        end
    end

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    // Timer 1: continuous up, or continuous up/down
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_reg <= '0;
            down_reg <= 1'b0;
        end else begin
            case (mode)
                FCP_UP: begin  // see R1
                    down_reg <= 1'b0;
                    cnt_reg <= perHit ? '0 : cnt_reg + 1'b1;
                end
                FCP_UPDOWN: begin  // see R1
                    if (perHit && !down_reg && !zeroHit) begin
                        down_reg <= 1'b1;
                        cnt_reg <= cnt_reg - 1'b1;
                    end else if (down_reg && cnt_reg == TW'(1)) begin
                        down_reg <= 1'b0;
                        cnt_reg <= '0;
                    end else if (down_reg) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else begin
                        cnt_reg <= perHit ? '0 : cnt_reg + 1'b1;
                    end
                end
                default: begin
                    down_reg <= down_reg;  // Stopped: hold
                end
            endcase
        end
    end

    // Timer 2: continuous up, runs whenever timer 1 runs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            t2Cnt_reg <= '0;
        end else if (mode == FCP_UP || mode == FCP_UPDOWN) begin
            t2Cnt_reg <= (t2Cnt_reg == t2Per_reg) ? '0 : t2Cnt_reg + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Compare and dead band
    // ----------------------------------------------------------------
    wire logic cmpOn = cmpCtrl_reg[CC_CMP_EN];
    wire logic [7:0] dbCount = deadBand_reg[DB_COUNT_LSB +: 8];  // see R8
    wire logic [2:0] dbEn = deadBand_reg[DB_EN_LSB +: 3];
    wire logic [1:0] dbPsc = deadBand_reg[DB_PSC_LSB +: 2];
    logic [2:0] raw;  // Compare waveform per channel
    logic [2:0] rawQ_reg;  // Previous waveform
    logic [7:0] dbCnt_reg [3];  // Dead-band timers
    logic [6:0] pscCnt_reg;  // Dead-band prescaler
    logic [2:0] upper, lower;  // Phase gate signals
    // Prescaler divides by 1, 2, 4 or 8
    wire logic dbTick = (pscCnt_reg & ((7'h01 << dbPsc) - 7'h01)) == 7'h00;

    // Level compare gives one edge per match; in centre-aligned mode
    // the up and down halves each cross the value once
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            raw[i] = cmpOn & (cnt_reg >= cmpAct_reg[i]);  // see R13
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pscCnt_reg <= 7'h00;
        end else begin
            pscCnt_reg <= pscCnt_reg + 7'h01;
        end
    end

    // A change of waveform on an enabled pair reloads the dead-band timer; both gates
    // stay low until it expires, which delays every rising edge
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rawQ_reg <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                dbCnt_reg[i] <= 8'h00;
            end
        end else begin
            rawQ_reg <= raw;
            for (int i = 0; i < 3; i++) begin
                if (raw[i] != rawQ_reg[i] && dbEn[i]) begin
                    dbCnt_reg[i] <= dbCount;  // see R21
                end else if (dbCnt_reg[i] != 8'h00 && dbTick) begin
                    dbCnt_reg[i] <= dbCnt_reg[i] - 8'h01;  // see R21
                end
            end
        end
    end

    // Gates are built from one waveform, so they can never both be high
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            upper[i] = rawQ_reg[i] & (dbCnt_reg[i] == 8'h00);  // see R15
            lower[i] = ~rawQ_reg[i] & (dbCnt_reg[i] == 8'h00);  // see R15
        end
    end

    // Upper gates as a pattern: bit 2 is phase a, bit 0 phase c.
    // Each leg toggles on its own, so a step between adjacent vectors
    // flips one bit when compare values are ordered by the software.
    wire logic [2:0] pattern = {upper[0], upper[1], upper[2]};  // see R16 R17
    wire logic zeroVector = (pattern == 3'h0) | (pattern == 3'h7);  // see R18

    // ----------------------------------------------------------------
    // Output logic
    // ----------------------------------------------------------------
    wire logic [TW-1:0] sBase = cmpCtrl_reg[CC_T2_SEL] ? t2Cnt_reg : cnt_reg;  // see R2
    wire logic sWave = cmpOn & (sBase >= sCmp_reg);
    wire logic protTrip = cmpCtrl_reg[CC_PROT_UNMASK] & ~powerDriveProtectN;
    wire logic drive = cmpCtrl_reg[CC_OE_HI] & cmpCtrl_reg[CC_OE_LO] & ~protTrip;
    logic [6:0] level_reg;
    logic [6:0] oeN_reg;

    // Pins 2i and 2i+1 are upper and lower of channel i; a forced
    // action on one pin holds it while its partner keeps switching
    always_ff @(posedge clk) begin
        if (!resetn) begin
            level_reg <= 7'h00;
            oeN_reg <= 7'h7F;  // see R19
        end else begin
            for (int i = 0; i < 3; i++) begin
                level_reg[2*i] <= polarity(actionAct_reg[4*i +: 2], upper[i]);  // see R9 R22
                level_reg[2*i+1] <= polarity(actionAct_reg[4*i+2 +: 2], lower[i]);  // see R9 R22
            end
            level_reg[6] <= polarity(cmpCtrl_reg[CC_SACT_LSB +: 2], sWave);  // see R22
            oeN_reg <= drive ? 7'h00 : 7'h7F;  // see R19
        end
    end
    // One driver for the whole bundle
    assign pins = {level_reg, oeN_reg};

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        case (addr_reg)
            OFF_ACTION: rdMux[15:0] = action_reg;
            OFF_DEADBAND: rdMux[15:0] = deadBand_reg;
            OFF_CMP1: rdMux[TW-1:0] = cmp_reg[0];
            OFF_CMP2: rdMux[TW-1:0] = cmp_reg[1];
            OFF_CMP3: rdMux[TW-1:0] = cmp_reg[2];
            OFF_CCTRL: rdMux[15:0] = cmpCtrl_reg;
            OFF_T1CTRL: rdMux[1:0] = t1Ctrl_reg;
            OFF_TIMER1_PERIOD: rdMux[TW-1:0] = per_reg;
            OFF_T2PER: rdMux[TW-1:0] = t2Per_reg;
            OFF_SCMP: rdMux[TW-1:0] = sCmp_reg;
            OFF_STATUS: begin
                rdMux[TW-1:0] = cnt_reg;
                rdMux[ST_PAT_LSB +: 3] = pattern;
                rdMux[ST_ZERO_VEC] = zeroVector;
                rdMux[ST_DIR] = down_reg;
            end
            default: rdMux = 32'h0000_0000;  // Unmapped reads zero
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rdPend_reg) begin
            hrdata_reg <= rdMux;
        end
    end

    // hsize is unused: only whole-word transfers are served
    wire logic unusedSize = ^hsize;
endmodule
`default_nettype wire

// >>> logic/fcp_pkg.sv
// Package: register map, field positions and reset values of the full compare PWM block
package fcp_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_ACTION = 8'h00;  // Output action control
    localparam logic [7:0] OFF_DEADBAND = 8'h04;  // Dead-band control
    localparam logic [7:0] OFF_CMP1 = 8'h08;  // Full compare value 1
    localparam logic [7:0] OFF_CMP2 = 8'h0C;  // Full compare value 2
    localparam logic [7:0] OFF_CMP3 = 8'h10;  // Full compare value 3
    localparam logic [7:0] OFF_CCTRL = 8'h14;  // Compare control
    localparam logic [7:0] OFF_T1CTRL = 8'h18;  // Timer 1 control
    localparam logic [7:0] OFF_TIMER1_PERIOD = 8'h1C;  // Timer 1 period
    localparam logic [7:0] OFF_STATUS = 8'h20;  // Read-only state
    localparam logic [7:0] OFF_T2PER = 8'h24;  // Timer 2 period
    localparam logic [7:0] OFF_SCMP = 8'h28;  // Simple compare value
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int DB_COUNT_LSB = 8;  // Dead-band count, bits 15:8
    localparam int DB_EN_LSB = 5;  // Per-pair enables, bits 7:5
    localparam int DB_PSC_LSB = 3;  // Prescaler, bits 4:3
    localparam int CC_CMP_EN = 15;  // Compare operation enable
    localparam int CC_OE_HI = 9;  // Output enable, high bit
    localparam int CC_OE_LO = 8;  // Output enable, low bit
    localparam int CC_SACT_LSB = 4;  // Simple output action, bits 5:4
    localparam int CC_PROT_UNMASK = 1;  // Protection input unmask
    localparam int CC_T2_SEL = 0;  // Simple unit uses timer 2
    localparam int ST_PAT_LSB = 16;  // Upper-leg pattern, bits 18:16
    localparam int ST_ZERO_VEC = 19;  // Pattern is a zero vector
    localparam int ST_DIR = 20;  // Timer 1 counting down
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_PERIOD = 16'hFFFF;
    // Timer 1 counting modes, from timer control bits 1:0
    typedef enum logic [1:0] {FCP_STOP, FCP_UP, FCP_UPDOWN, FCP_RSVD} fcp_mode_t;
    // Pin bundle toward the gate drivers; enables are active low
    typedef struct packed {
        logic [6:0] level;  // Pins 5..0 full pairs, pin 6 simple output
        logic [6:0] oeN;  // Low while the pin is driven
    } fcp_pins_t;
endpackage
